// ===== hdl/vfo_pkg.sv
package vfo_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_TIMING = 8'h04;
	localparam logic [7:0] ADDR_FETCH_CTRL = 8'h08;
	localparam logic [7:0] ADDR_START = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_PEN = 8'h14;
	// ----------------------------------------
	// config fields
	// ----------------------------------------
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_PIN_LSB = 2;
	localparam int CFG_INTERLACE_BIT = 4;
	localparam int CFG_DBLH_BIT = 5;
	localparam int CFG_ROWTABLE_BIT = 6;
	localparam int CFG_ENABLE_BIT = 7;
	// ----------------------------------------
	// timing and fetch control fields
	// ----------------------------------------
	localparam int TIM_CHARS_LSB = 0;
	localparam int TIM_HTOT_LSB = 8;
	localparam int TIM_LINES_LSB = 16;
	localparam int TIM_ROWS_LSB = 21;
	localparam int TIM_VRET_LSB = 26;
	localparam int FC_BURST_LSB = 0;
	localparam int FC_DELAY_LSB = 8;
	localparam int FC_OFF_BIT = 16;
	localparam logic [31:0] TIMING_RESET = 32'h0C2B_5050;
	localparam logic [31:0] FETCH_RESET = 32'h0000_1008;
	localparam logic [7:0] HSYNC_WIDTH = 8'h08;
	localparam logic [7:0] EQ_WIDTH = 8'h04;
	localparam logic [2:0] SERIAL_SHORT = 3'h5;
	localparam logic [2:0] SERIAL_LONG = 3'h6;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [1:0] {VFO_SINGLE, VFO_DOUBLE, VFO_REPEAT, VFO_NONE} vfo_mode_e;
	typedef enum logic [1:0] {VFO_PINS_PAR, VFO_PINS_SER, VFO_PINS_DMA, VFO_PINS_SYNC} vfo_pins_e;
	typedef enum {VFO_F_IDLE, VFO_F_REQ, VFO_F_ADDR, VFO_F_WRITE, VFO_F_GAP} vfo_fetch_e;

	typedef struct packed {
		logic [31:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [31:0] araddr;
		logic arvalid;
		logic rready;
	} vfo_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} vfo_axi_rsp_s;

	typedef struct packed {
		logic [3:0] pin;
		logic rowBoundary_n;
		logic [13:0] addr;
		logic addrOe_n;
	} vfo_pins_s;
endpackage

// ===== hdl/vfo_serial_line.sv
`timescale 1ns/1ps
// shifts the scan line count out lsb first inside a low gate window
module vfo_serial_line (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// control
	input wire logic start,
	input wire logic extraShift,
	input wire logic [4:0] count,
	// serial outputs
	output logic gate_n,
	output logic bitOut
);
	import vfo_pkg::*;

	typedef struct packed {
		logic [2:0] left;
		logic [5:0] shreg;
		logic gate_n;
		logic bitOut;
	} vfo_ser_s;

	vfo_ser_s st_q, st_d;

	always_comb begin
		st_d = st_q;
		if (st_q.left != 3'h0) begin
			st_d.gate_n = 1'b0;
			st_d.bitOut = st_q.shreg[0];
			st_d.shreg = {1'b0, st_q.shreg[5:1]};
			st_d.left = st_q.left - 3'h1;
		end else begin
			st_d.gate_n = 1'b1;
			st_d.bitOut = 1'b0;
			if (start) begin
				// leading dummy bit so the last five shifted are the count
				st_d.left = extraShift ? SERIAL_LONG : SERIAL_SHORT;
				st_d.shreg = extraShift ? {count, 1'b0} : {1'b0, count};
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '{left: 3'h0, shreg: 6'h00, gate_n: 1'b1, bitOut: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign gate_n = st_q.gate_n;
	assign bitOut = st_q.bitOut;
endmodule

// ===== hdl/vfo_video_fetch.sv
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module vfo_video_fetch (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// register bus
	input wire vfo_pkg::vfo_axi_req_s axiReq,
	output vfo_pkg::vfo_axi_rsp_s axiRsp,
	// external pins
	input wire logic fetchGrant,
	input wire logic pointerStrobeIn,
	input wire logic addressFloat_n,
	output vfo_pkg::vfo_pins_s pins
);
	import vfo_pkg::*;

	typedef struct packed {
		vfo_axi_rsp_s rsp;
		logic awHave;
		logic wHave;
		logic [7:0] awAddr;
		logic [31:0] wData;
		logic [7:0] cfg;
		logic [31:0] timing;
		logic [31:0] fetchCtl;
		logic [13:0] startAddr;
		logic [7:0] col;
		logic [4:0] line;
		logic [4:0] row;
		logic [4:0] vline;
		logic vret;
		logic field;
		logic [13:0] rowBase;
		logic [13:0] nextBase;
		logic [7:0] fetched;
		logic [7:0] burst;
		logic [7:0] gap;
		vfo_fetch_e fst;
		logic req;
		logic wgate;
		logic [15:0] pen;
		logic [2:0] grantSync;
		logic [2:0] penSync;
		logic [1:0] floatSync;
		logic serStart;
		vfo_pins_s pins;
	} vfo_state_s;

	vfo_state_s s_q, s_d;
	logic serGate_n, serBit;

	function automatic logic addrHit(input logic [31:0] a, input logic [7:0] off);
		addrHit = (a[7:0] == off) && (a[31:8] == 24'h000000);
	endfunction

	vfo_serial_line u_serial (
		.clk(clk),
		.arst_n(arst_n),
		.start(s_q.serStart),
		.extraShift(s_q.cfg[CFG_INTERLACE_BIT] | s_q.cfg[CFG_DBLH_BIT]),
		.count(s_q.line),
		.gate_n(serGate_n),
		.bitOut(serBit)
	);

	logic [7:0] chars, htot, burstLen, gapLen;
	logic [4:0] lines, rows, vlines;
	logic grant, penRise, floatReq, lineEnd, inHret, rowTop, fetchOn, combined_sync_out;
	vfo_mode_e mode;
	vfo_pins_e pinSel;

	always_comb begin
		chars = s_q.timing[TIM_CHARS_LSB +: 8];
		htot = s_q.timing[TIM_HTOT_LSB +: 8];
		lines = s_q.timing[TIM_LINES_LSB +: 5];
		rows = s_q.timing[TIM_ROWS_LSB +: 5];
		vlines = s_q.timing[TIM_VRET_LSB +: 5];
		burstLen = s_q.fetchCtl[FC_BURST_LSB +: 8];
		gapLen = s_q.fetchCtl[FC_DELAY_LSB +: 8];
		mode = vfo_mode_e'(s_q.cfg[CFG_MODE_LSB +: 2]);
		pinSel = vfo_pins_e'(s_q.cfg[CFG_PIN_LSB +: 2]);
		grant = s_q.grantSync[1];
		penRise = s_q.penSync[1] & ~s_q.penSync[2];
		floatReq = ~s_q.floatSync[1];
		lineEnd = (s_q.col == htot);
		inHret = (s_q.col >= chars);
		rowTop = (s_q.line == 5'h00);
		// zero burst is the fetch-off setting too
		fetchOn = s_q.cfg[CFG_ENABLE_BIT] & ~s_q.fetchCtl[FC_OFF_BIT]
			& (burstLen != 8'h00) & (mode == VFO_DOUBLE);
		// ----------------------------------------
		// composite sync: hsync, or inverted serrations/equalizers in vret
		// ----------------------------------------
		if (s_q.vret && s_q.vline < 5'h03) begin
			combined_sync_out = (s_q.col < EQ_WIDTH) ||
				(s_q.field && s_q.col >= (htot >> 1) && s_q.col < (htot >> 1) + EQ_WIDTH);
		end else if (s_q.vret && s_q.vline < 5'h06) begin
			combined_sync_out = (s_q.col < (htot >> 1) - HSYNC_WIDTH) ||
				(s_q.col >= (htot >> 1) && s_q.col < htot - HSYNC_WIDTH);
		end else begin
			combined_sync_out = (s_q.col >= chars) && (s_q.col < chars + HSYNC_WIDTH);
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.grantSync = {s_q.grantSync[1:0], fetchGrant};
		s_d.penSync = {s_q.penSync[1:0], pointerStrobeIn};
		s_d.floatSync = {s_q.floatSync[0], addressFloat_n};
		s_d.serStart = 1'b0;
		// ----------------------------------------
		// axi4-lite slave
		// ----------------------------------------
		if (axiReq.awvalid && s_q.rsp.awready) begin
			s_d.awHave = 1'b1;
			s_d.awAddr = axiReq.awaddr[7:0];
			s_d.rsp.awready = 1'b0;
			if (axiReq.awaddr[31:8] != 24'h000000) s_d.awAddr = 8'hFF;
		end
		if (axiReq.wvalid && s_q.rsp.wready) begin
			s_d.wHave = 1'b1;
			s_d.wData = axiReq.wdata;
			s_d.rsp.wready = 1'b0;
		end
		if (s_q.awHave && s_q.wHave && !s_q.rsp.bvalid) begin
			s_d.rsp.bvalid = 1'b1;
			s_d.rsp.bresp = AXI_OKAY;
			case (s_q.awAddr)
				ADDR_CONFIG: s_d.cfg = s_q.wData[7:0];
				ADDR_TIMING: s_d.timing = s_q.wData;
				ADDR_FETCH_CTRL: s_d.fetchCtl = s_q.wData;
				ADDR_START: s_d.startAddr = s_q.wData[13:0];
				ADDR_STATUS, ADDR_PEN: ;
				default: s_d.rsp.bresp = AXI_SLVERR;
			endcase
		end
		if (s_q.rsp.bvalid && axiReq.bready) begin
			s_d.rsp.bvalid = 1'b0;
			s_d.awHave = 1'b0;
			s_d.wHave = 1'b0;
			s_d.rsp.awready = 1'b1;
			s_d.rsp.wready = 1'b1;
		end
		if (axiReq.arvalid && s_q.rsp.arready) begin
			s_d.rsp.arready = 1'b0;
			s_d.rsp.rvalid = 1'b1;
			s_d.rsp.rresp = AXI_OKAY;
			if (addrHit(axiReq.araddr, ADDR_CONFIG)) s_d.rsp.rdata = {24'h000000, s_q.cfg};
			else if (addrHit(axiReq.araddr, ADDR_TIMING)) s_d.rsp.rdata = s_q.timing;
			else if (addrHit(axiReq.araddr, ADDR_FETCH_CTRL)) s_d.rsp.rdata = s_q.fetchCtl;
			else if (addrHit(axiReq.araddr, ADDR_START)) s_d.rsp.rdata = {18'h00000, s_q.startAddr};
			else if (addrHit(axiReq.araddr, ADDR_STATUS)) s_d.rsp.rdata =
				{12'h000, s_q.fetched, s_q.vret, s_q.req, s_q.row, s_q.line};
			else if (addrHit(axiReq.araddr, ADDR_PEN)) s_d.rsp.rdata = {16'h0000, s_q.pen};
			else begin
				s_d.rsp.rdata = 32'h00000000;
				s_d.rsp.rresp = AXI_SLVERR;
			end
		end
		if (s_q.rsp.rvalid && axiReq.rready) begin
			s_d.rsp.rvalid = 1'b0;
			s_d.rsp.arready = 1'b1;
		end
		// ----------------------------------------
		// raster counters
		// ----------------------------------------
		if (penRise) s_d.pen = {s_q.row, 3'h0, s_q.col};
		if (!s_q.cfg[CFG_ENABLE_BIT]) begin
			s_d.col = 8'h00;
		end else if (lineEnd) begin
			s_d.col = 8'h00;
			s_d.serStart = 1'b1;
			if (s_q.vret) begin
				s_d.line = s_q.line + 5'h01;
				s_d.vline = s_q.vline + 5'h01;
				if (s_q.vline == vlines) begin
					s_d.vret = 1'b0;
					s_d.vline = 5'h00;
					s_d.line = 5'h00;
					s_d.row = 5'h00;
					s_d.field = s_q.cfg[CFG_INTERLACE_BIT] & ~s_q.field;
					s_d.rowBase = s_q.startAddr;
					s_d.nextBase = s_q.startAddr;
				end
			end else if (s_q.line == lines) begin
				s_d.line = 5'h00;
				s_d.rowBase = s_q.rowBase + {6'h00, chars};
				if (s_q.row == rows) begin
					s_d.vret = 1'b1;
					s_d.line = 5'h00;
				end else begin
					s_d.row = s_q.row + 5'h01;
				end
			end else begin
				s_d.line = s_q.line + 5'h01;
			end
		end else begin
			s_d.col = s_q.col + 8'h01;
		end
		// ----------------------------------------
		// next-row fetch engine
		// ----------------------------------------
		if (lineEnd && rowTop && !s_q.vret) begin
			s_d.fetched = 8'h00;
			s_d.nextBase = s_q.rowBase + {6'h00, chars};
		end
		s_d.wgate = 1'b0;
		case (s_q.fst)
			VFO_F_IDLE: begin
				if (fetchOn && s_q.fetched != chars && !grant) begin
					s_d.req = 1'b1;
					s_d.fst = VFO_F_REQ;
					s_d.burst = 8'h00;
				end
			end
			VFO_F_REQ: begin
				if (grant) s_d.fst = VFO_F_ADDR;
			end
			VFO_F_ADDR: begin
				s_d.wgate = 1'b1;
				s_d.fst = VFO_F_WRITE;
			end
			VFO_F_WRITE: begin
				s_d.fetched = s_q.fetched + 8'h01;
				s_d.burst = s_q.burst + 8'h01;
				if (s_q.burst + 8'h01 == burstLen || s_q.fetched + 8'h01 == chars) begin
					s_d.req = 1'b0;
					s_d.gap = 8'h00;
					s_d.fst = VFO_F_GAP;
				end else begin
					s_d.fst = VFO_F_ADDR;
				end
			end
			VFO_F_GAP: begin
				s_d.gap = s_q.gap + 8'h01;
				if (s_q.gap >= gapLen) s_d.fst = VFO_F_IDLE;
			end
			default: s_d.fst = VFO_F_IDLE;
		endcase
		if (!fetchOn && s_q.fst == VFO_F_IDLE) s_d.req = 1'b0;
		// ----------------------------------------
		// video address and float
		// ----------------------------------------
		s_d.pins.addrOe_n = 1'b1;
		s_d.pins.addr = s_q.rowBase + {6'h00, s_q.col};
		case (mode)
			VFO_DOUBLE: begin
				s_d.pins.addr = s_q.nextBase + {6'h00, s_q.fetched};
				s_d.pins.addrOe_n = !(s_q.fst == VFO_F_ADDR || s_q.fst == VFO_F_WRITE);
			end
			VFO_SINGLE: s_d.pins.addrOe_n = !(rowTop && !s_q.vret && !inHret);
			VFO_REPEAT: begin
				// same base each line, so every line of the row replays
				s_d.pins.addrOe_n = s_q.vret || (inHret &&
					!(s_q.cfg[CFG_ROWTABLE_BIT] && s_q.line == lines));
			end
			default: s_d.pins.addrOe_n = 1'b1;
		endcase
		if (floatReq) s_d.pins.addrOe_n = 1'b1;
		s_d.pins.rowBoundary_n = !((rowTop || (s_q.vret && s_q.vline == 5'h00))
			&& s_q.cfg[CFG_ENABLE_BIT]);
		// ----------------------------------------
		// shared pin selection
		// ----------------------------------------
		case (pinSel)
			VFO_PINS_PAR: s_d.pins.pin = s_q.line[3:0];
			VFO_PINS_SER: s_d.pins.pin = {serBit, serGate_n, combined_sync_out, s_q.vret};
			VFO_PINS_DMA: s_d.pins.pin = {1'b0, 1'b0, s_q.wgate, s_q.req};
			VFO_PINS_SYNC: s_d.pins.pin = {1'b0, 1'b0, combined_sync_out, s_q.vret};
			default: s_d.pins.pin = 4'h0;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
			s_q.rsp.awready <= 1'b1;
			s_q.rsp.wready <= 1'b1;
			s_q.rsp.arready <= 1'b1;
			s_q.timing <= TIMING_RESET;
			s_q.fetchCtl <= FETCH_RESET;
			s_q.fst <= VFO_F_IDLE;
			s_q.floatSync <= 2'h3;
			s_q.pins <= '{pin: 4'h0, rowBoundary_n: 1'b1, addr: 14'h0000, addrOe_n: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	assign axiRsp = s_q.rsp;
	assign pins = s_q.pins;
endmodule

// ===== bench/vfo_video_fetch_chk.sv
`timescale 1ns/1ps
module vfo_video_fetch_chk (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// watched ports
	input wire vfo_pkg::vfo_axi_req_s axiReq,
	input wire vfo_pkg::vfo_axi_rsp_s axiRsp,
	input wire logic fetchGrant,
	input wire logic pointerStrobeIn,
	input wire logic addressFloat_n,
	input wire vfo_pkg::vfo_pins_s pins
);
	import vfo_pkg::*;
	logic [7:0] cfg_q;
	logic off_q;
	logic [5:0] age_q;
	logic wrTaken;
	logic ok;
	logic [1:0] sel;
	// ----------------------------------------
	// config shadow
	// ----------------------------------------
	assign wrTaken = axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
	// pin meaning trusted only well after a write, so a burst in flight may finish
	assign ok = age_q == 6'h3F;
	assign sel = cfg_q[3:2];
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_q <= 8'h00;
			off_q <= 1'b0;
			age_q <= 6'h00;
		end else begin
			age_q <= wrTaken ? 6'h00 : (ok ? age_q : age_q + 6'h01);
			if (wrTaken && axiReq.awaddr[7:0] == ADDR_CONFIG) begin
				cfg_q <= axiReq.wdata[7:0];
			end
			if (wrTaken && axiReq.awaddr[7:0] == ADDR_FETCH_CTRL) begin
				off_q <= axiReq.wdata[16] || axiReq.wdata[7:0] == 8'h00;
			end
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	sequence sGateLow;
		!pins.pin[2] [*5];
	endsequence
	sequence sGateEnd;
		pins.pin[2] or (!pins.pin[2] ##1 pins.pin[2]);
	endsequence
	a_float_addr: assert property (!addressFloat_n [*4] |-> pins.addrOe_n)
		else $error("address driven while float input low");
	a_req_no_grant: assert property (
		ok && sel == VFO_PINS_DMA && $rose(pins.pin[0]) |-> !fetchGrant)
		else $error("request raised while granted");
	a_gate_pulse: assert property (
		ok && sel == VFO_PINS_DMA && pins.pin[1] |-> fetchGrant ##1 !pins.pin[1])
		else $error("write gate outside grant or too long");
	a_off_quiet: assert property (
		ok && sel == VFO_PINS_DMA && off_q |-> pins.pin[1:0] == 2'b00)
		else $error("fetch activity while disabled");
	a_serial_win: assert property (
		ok && sel == VFO_PINS_SER && $fell(pins.pin[2]) |-> sGateLow ##1 sGateEnd)
		else $error("serial gate window not five or six clocks");
	a_par_count: assert property (
		ok && sel == VFO_PINS_PAR && pins.pin != $past(pins.pin)
		|-> pins.pin == $past(pins.pin) + 4'h1 || pins.pin == 4'h0)
		else $error("parallel line count skipped");
	a_rd_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
		else $error("read answer late");
	a_err_zero: assert property (axiRsp.rvalid && axiRsp.rresp == AXI_SLVERR
		|-> axiRsp.rdata == 32'h0)
		else $error("refused read returned data");
	// line count below sixteen here, so a zero count marks the row's top line
	a_row_edge: assert property (
		ok && cfg_q[7] && sel == VFO_PINS_PAR |-> pins.rowBoundary_n == (pins.pin != 4'h0))
		else $error("row boundary off the top line");
	a_single_top: assert property (
		ok && cfg_q[7] && cfg_q[1:0] == VFO_SINGLE && !pins.addrOe_n |-> !pins.rowBoundary_n)
		else $error("single buffer address off the top line");
	a_vertical_blank_flag_start: assert property (
		ok && cfg_q[7] && (sel == VFO_PINS_SER || sel == VFO_PINS_SYNC) && $rose(pins.pin[0])
		|-> !pins.rowBoundary_n)
		else $error("vertical blank began off the first retrace line");
endmodule

bind vfo_video_fetch vfo_video_fetch_chk vfo_video_fetch_chk_i (
	.clk(clk), .arst_n(arst_n), .axiReq(axiReq), .axiRsp(axiRsp),
	.fetchGrant(fetchGrant), .pointerStrobeIn(pointerStrobeIn),
	.addressFloat_n(addressFloat_n), .pins(pins)
);

// ===== bench/vfo_fetch_partner.sv
`timescale 1ns/1ps
// shared bus arbiter and write gate tally on the far side of the fetch link
module vfo_fetch_partner (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// fetch link
	input wire logic request,
	input wire logic writeGate,
	input wire logic [2:0] latency,
	output logic grant,
	// tallies
	output int grants,
	output int maxBurst
);
	int wait_q;
	int count_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			grant <= 1'b0;
			wait_q <= 0;
			count_q <= 0;
			grants <= 0;
			maxBurst <= 0;
		end else begin
			if (writeGate) begin
				count_q <= count_q + 1;
				maxBurst <= (count_q >= maxBurst) ? count_q + 1 : maxBurst;
			end
			if (!request) begin
				// withdrawn only once the request is gone, never mid fetch
				grant <= 1'b0;
				wait_q <= 0;
				count_q <= 0;
			end else if (!grant) begin
				wait_q <= wait_q + 1;
				if (wait_q >= int'(latency)) begin
					grant <= 1'b1;
					grants <= grants + 1;
				end
			end
		end
	end
endmodule

// ===== bench/vfo_video_fetch_tb_top.sv
`timescale 1ns/1ps
module vfo_video_fetch_tb_top;
	import vfo_pkg::*;
	logic clk;
	logic arst_n;
	vfo_axi_req_s axiReq;
	vfo_axi_rsp_s axiRsp;
	logic fetchGrant;
	logic pointerStrobeIn;
	logic addressFloat_n;
	vfo_pins_s pins;
	logic dmaOn;
	logic [2:0] latency;
	int grants, maxBurst;
	int numErrors = 0, checked = 0, cycles = 0, mon = 0, expLen = 5;
	int bitCnt = 0, val = 0, prevVal = -1, g = 0;
	int seed = 32'h619a;
	int penPrev = -1, waitN = 0;
	int lineLen = int'(TIMING_RESET[TIM_HTOT_LSB +: 8]) + 1;
	logic [31:0] rd;
	logic [1:0] rr;
	logic [31:0] regs [logic [7:0]];
	vfo_video_fetch vfo_video_fetch_i (
		.clk(clk), .arst_n(arst_n), .axiReq(axiReq), .axiRsp(axiRsp),
		.fetchGrant(fetchGrant), .pointerStrobeIn(pointerStrobeIn),
		.addressFloat_n(addressFloat_n), .pins(pins)
	);
	vfo_fetch_partner vfo_fetch_partner_i (
		.clk(clk), .arst_n(arst_n), .request(dmaOn && pins.pin[0]),
		.writeGate(dmaOn && pins.pin[1]), .latency(latency), .grant(fetchGrant),
		.grants(grants), .maxBurst(maxBurst)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			numErrors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", checked, numErrors);
		if (numErrors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		axiReq.awaddr <= {24'h0, a};
		axiReq.wdata <= d;
		axiReq.awvalid <= 1'b1;
		axiReq.wvalid <= 1'b1;
		axiReq.bready <= 1'b1;
		do begin
			@(posedge clk);
			if (axiRsp.awready) axiReq.awvalid <= 1'b0;
			if (axiRsp.wready) axiReq.wvalid <= 1'b0;
		end while (axiRsp.bvalid !== 1'b1);
		axiReq.bready <= 1'b0;
		chk("bresp", (a <= ADDR_PEN) ? AXI_OKAY : AXI_SLVERR, axiRsp.bresp);
		if (a inside {ADDR_TIMING, ADDR_FETCH_CTRL}) regs[a] = d;
		if (a == ADDR_CONFIG) regs[a] = d & 32'h0000_00FF;
		if (a == ADDR_START) regs[a] = d & 32'h0000_3FFF;
	endtask
	task automatic regRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		axiReq.araddr <= {24'h0, a};
		axiReq.arvalid <= 1'b1;
		axiReq.rready <= 1'b1;
		do begin
			@(posedge clk);
			if (axiRsp.arready) axiReq.arvalid <= 1'b0;
		end while (axiRsp.rvalid !== 1'b1);
		axiReq.rready <= 1'b0;
		d = axiRsp.rdata;
		r = axiRsp.rresp;
	endtask
	task automatic regCheck(input logic [7:0] a);
		logic [31:0] d;
		logic [1:0] r;
		regRead(a, d, r);
		chk("rresp", regs.exists(a) ? AXI_OKAY : AXI_SLVERR, r);
		chk("rdata", regs.exists(a) ? regs[a] : 32'h0, d);
	endtask
	task automatic serialPhase(input logic [31:0] cfg, input int len, input int m);
		mon = 0;
		regWrite(ADDR_CONFIG, cfg);
		repeat (100) @(posedge clk);
		@(posedge clk iff pins.pin[2] === 1'b1);
		bitCnt = 0;
		val = 0;
		prevVal = -1;
		expLen = len;
		mon = m;
		repeat (2500) @(posedge clk);
		mon = 0;
		chk("windows", 1, prevVal >= 0);
	endtask
	// ----------------------------------------
	// serial receiver model and watchdog
	// ----------------------------------------
	always @(posedge clk) begin
		cycles++;
		if (cycles > 40000) begin
			numErrors++;
			end_of_test();
		end
	end
	always @(posedge clk) begin
		if (mon != 0 && pins.pin[2] === 1'b0) begin
			// five-bit receiver: a leading extra bit falls off the end
			val = (val >> 1) | (int'(pins.pin[3]) << 4);
			bitCnt++;
		end else if (mon != 0 && bitCnt > 0) begin
			chk("gate len", expLen, bitCnt);
			if (mon == 1 && prevVal >= 0) begin
				chk("line", 1, val == (prevVal + 1) % 12 || val == 0);
			end
			prevVal = val;
			val = 0;
			bitCnt = 0;
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		arst_n = 1'b0;
		axiReq = '0;
		pointerStrobeIn = 1'b0;
		addressFloat_n = 1'b1;
		dmaOn = 1'b0;
		latency = 3'h1;
		regs[ADDR_TIMING] = TIMING_RESET;
		regs[ADDR_FETCH_CTRL] = FETCH_RESET;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		regCheck(ADDR_TIMING);
		regCheck(ADDR_FETCH_CTRL);
		regCheck(8'h18);
		regWrite(8'h18, 32'h1234_5678);
		regWrite(ADDR_CONFIG, 32'h0000_0080);
		regCheck(ADDR_CONFIG);
		regWrite(ADDR_START, 32'h0000_0001);
		regCheck(ADDR_START);
		repeat (2500) @(posedge clk);
		serialPhase(32'h0000_0084, 5, 1);
		serialPhase(32'h0000_0094, 6, 2);
		regWrite(ADDR_FETCH_CTRL, 32'h0000_0804);
		regCheck(ADDR_FETCH_CTRL);
		regWrite(ADDR_CONFIG, 32'h0000_0089);
		dmaOn <= 1'b1;
		repeat (30) begin
			latency <= 3'($random(seed));
			repeat (100) @(posedge clk);
		end
		chk("burst", 4, maxBurst);
		chk("granted", 1, grants > 0);
		regWrite(ADDR_FETCH_CTRL, 32'h0001_0804);
		repeat (100) @(posedge clk);
		g = grants;
		repeat (1500) @(posedge clk);
		chk("idle grants", g, grants);
		dmaOn <= 1'b0;
		regWrite(ADDR_CONFIG, 32'h0000_008E);
		repeat (40) begin
			addressFloat_n <= 1'b0;
			pointerStrobeIn <= 1'b1;
			repeat (8) @(posedge clk);
			chk("float", 1, pins.addrOe_n);
			addressFloat_n <= 1'b1;
			pointerStrobeIn <= 1'b0;
			// read costs three edges, so strobe rises are 11 plus the wait apart
			regRead(ADDR_PEN, rd, rr);
			if (penPrev >= 0) chk("pen col", (penPrev + 11 + waitN) % lineLen, rd[7:0]);
			chk("pen pad", 0, rd[10:8]);
			penPrev = rd[7:0];
			waitN = 32 + ($random(seed) & 31);
			repeat (waitN) @(posedge clk);
		end
		end_of_test();
	end
endmodule
